// file: design/pcm_port_map.vh
// constants for the pcm codec serial port: register map, field
// positions, reset values and timing counts.
// assumes a 40 MHz pclk and a 32-bit apb register bus.
`ifndef PCM_PORT_MAP_VH
`define PCM_PORT_MAP_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define REG_TX_WORD         12'h000
`define REG_RX_WORD         12'h004
`define REG_STATUS          12'h008

// ****************************************************************
// status register fields
// ****************************************************************
`define ST_VARIABLE_MODE    0
`define ST_A_LAW            1
`define ST_POWERED          2
`define ST_RX_STANDBY       3
`define ST_TX_STANDBY       4
`define ST_RX_SIGNALING     5
`define ST_TX_SIGNALING     6
`define ST_RX_NEW           7
`define ST_TX_TAKEN         8
`define ST_FREQ_LO          9
`define ST_FREQ_HI          10

// ****************************************************************
// reset values
// ****************************************************************
`define TX_WORD_RESET       8'hff
`define RX_WORD_RESET       8'h00

// ****************************************************************
// word format and timing
// ****************************************************************
`define PCM_WORD_BITS       4'h8
`define SYNC_LEN_SIGNALING  2'h2
`define STANDBY_MS          300
`define PCLK_KHZ            40000

`endif

// file: design/pin_sync.v
// two-flop synchroniser for a group of independent pin levels.
// assumes each bit is a slow level or a clock far below pclk; bits
// are not coherent with one another after the crossing.
`timescale 1ns/1ps

module pin_sync #(
    parameter WIDTH = 1
)
(
    // clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // pin levels in and synchronised levels out
    input  wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] pin_out
);

// ****************************************************************
// two stages per bit
// ****************************************************************
genvar i;
generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
        reg meta_r;
        reg stable_r;
        // first stage is read only by the second
        always @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                meta_r   <= 1'b0;
                stable_r <= 1'b0;
            end
            else
            begin
                meta_r   <= pin_in[i];
                stable_r <= meta_r;
            end
        end
        assign pin_out[i] = stable_r;
    end
endgenerate

endmodule

// file: design/pcm_codec_serial_port.v
// serial pcm port of a voice-band codec with apb register access.
// assumes all pin inputs are asynchronous to pclk and at least eight
// times slower than pclk; analog path is outside this block.
`timescale 1ns/1ps
`include "pcm_port_map.vh"

module pcm_codec_serial_port #(
    parameter STANDBY_CYCLES = `STANDBY_MS * `PCLK_KHZ
)
(
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire [11:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // straps and power control
    input  wire        mode_strap_vbb,
    input  wire        companding_law_strap,
    input  wire [1:0]  master_freq_strap,
    input  wire        power_down_n,
    // clocks from the highway
    input  wire        rx_master_clock,
    input  wire        rx_bit_clock_or_mode_pin,
    // frame strobes
    input  wire        rx_frame_strobe,
    input  wire        tx_frame_strobe,
    // transmit slot strobe or bit clock, open drain
    input  wire        tx_slot_strobe_or_bit_clock_in,
    output wire        tx_slot_strobe_or_bit_clock_out,
    output wire        tx_slot_strobe_or_bit_clock_oe,
    // pcm data
    input  wire        pcm_in,
    output reg         pcm_out,
    output reg         pcm_out_en
);

// ****************************************************************
// pin synchronisers
// ****************************************************************
localparam [3:0] LAST_BIT = `PCM_WORD_BITS - 4'h1;
localparam [31:0] STANDBY_WIDE  = STANDBY_CYCLES - 1;
localparam [23:0] STANDBY_LIMIT = STANDBY_WIDE[23:0];

wire [10:0] pins_s;

pin_sync #(
    .WIDTH (11)
)
u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  ({power_down_n, mode_strap_vbb, companding_law_strap,
               master_freq_strap, rx_master_clock, rx_bit_clock_or_mode_pin,
               tx_slot_strobe_or_bit_clock_in, rx_frame_strobe,
               tx_frame_strobe, pcm_in}),
    .pin_out (pins_s)
);

wire       powered_s  = pins_s[10];
wire       variable_s = ~pins_s[9];
wire       a_law_s    = pins_s[8];
wire [1:0] freq_s     = pins_s[7:6];
wire       mclk_s     = pins_s[5];
wire       rxbclk_s   = pins_s[4];
wire       txbclk_s   = pins_s[3];
wire       rx_fs_s    = pins_s[2];
wire       tx_fs_s    = pins_s[1];
wire       pcm_in_s   = pins_s[0];

// ****************************************************************
// data clock selection and edge detection
// ****************************************************************
reg mclk_d_r;
reg rxbclk_d_r;
reg txbclk_d_r;

// previous levels of each synchronised clock
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        mclk_d_r   <= 1'b0;
        rxbclk_d_r <= 1'b0;
        txbclk_d_r <= 1'b0;
    end
    else
    begin
        mclk_d_r   <= mclk_s;
        rxbclk_d_r <= rxbclk_s;
        txbclk_d_r <= txbclk_s;
    end
end

// one master clock serves both directions in fixed mode; bit clocks only in variable mode
wire mclk_fall = mclk_d_r & ~mclk_s;
wire mclk_rise = ~mclk_d_r & mclk_s;
wire rx_fall   = variable_s ? (rxbclk_d_r & ~rxbclk_s) : mclk_fall;
wire tx_rise   = variable_s ? (~txbclk_d_r & txbclk_s) : mclk_rise;
wire tx_fall   = variable_s ? (txbclk_d_r & ~txbclk_s) : mclk_fall;

// ****************************************************************
// per-channel strobe length and standby timing
// ****************************************************************
wire [1:0] strobe  = {tx_fs_s, rx_fs_s};
wire [1:0] dfall   = {tx_fall, rx_fall};
wire [1:0] signaling;
wire [1:0] standby;

genvar ch;
generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_chan
        reg [1:0]  len_r;
        reg        prev_r;
        reg        sig_r;
        reg [23:0] idle_r;
        reg        standby_r;

        // length in data periods classifies the frame in fixed mode
        always @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                len_r  <= 2'h0;
                prev_r <= 1'b0;
                sig_r  <= 1'b0;
            end
            else
            begin
                prev_r <= strobe[ch];
                if (strobe[ch] && dfall[ch] && len_r != 2'h3)
                    len_r <= len_r + 2'h1;
                else if (!strobe[ch] && prev_r)
                begin
                    len_r <= 2'h0;
                    if (!variable_s)
                        sig_r <= (len_r >= `SYNC_LEN_SIGNALING);
                end
            end
        end

        // low for the full interval parks the channel; any high wakes it
        always @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                idle_r    <= 24'h0;
                standby_r <= 1'b0;
            end
            else if (strobe[ch])
            begin
                idle_r    <= 24'h0;
                standby_r <= 1'b0;
            end
            else if (idle_r == STANDBY_LIMIT)
                standby_r <= 1'b1;
            else
                idle_r <= idle_r + 24'h1;
        end

        assign signaling[ch] = sig_r;
        assign standby[ch]   = standby_r;
    end
endgenerate

wire rx_active = powered_s & ~standby[0];
wire tx_active = powered_s & ~standby[1];

// ****************************************************************
// receive shifter
// ****************************************************************
reg [7:0] rx_shift_r;
reg [3:0] rx_cnt_r;
reg       rx_busy_r;
reg [7:0] rx_word_r;
reg       rx_done;

// msb first; a slot enable dropping early discards the partial word
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        rx_shift_r <= 8'h00;
        rx_cnt_r   <= 4'h0;
        rx_busy_r  <= 1'b0;
        rx_word_r  <= `RX_WORD_RESET;
        rx_done    <= 1'b0;
    end
    else
    begin
        rx_done <= 1'b0;
        if (!rx_active || (variable_s && rx_busy_r && !rx_fs_s))
        begin
            rx_busy_r <= 1'b0;
            rx_cnt_r  <= 4'h0;
        end
        else if (rx_fall && (rx_busy_r || rx_fs_s))
        begin
            rx_shift_r <= {rx_shift_r[6:0], pcm_in_s};
            if (rx_busy_r && rx_cnt_r == LAST_BIT)
            begin
                rx_word_r <= {rx_shift_r[6:0], pcm_in_s};
                rx_done   <= 1'b1;
                rx_busy_r <= 1'b0;
                rx_cnt_r  <= 4'h0;
            end
            else
            begin
                rx_busy_r <= 1'b1;
                rx_cnt_r  <= rx_cnt_r + 4'h1;
            end
        end
    end
end

// ****************************************************************
// transmit shifter
// ****************************************************************
reg [7:0] tx_word_r;
reg [7:0] tx_shift_r;
reg [3:0] tx_cnt_r;
reg       tx_busy_r;
reg       tx_load;

// the ninth rising edge ends the slot and releases the data pin
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        tx_shift_r <= 8'h00;
        tx_cnt_r   <= 4'h0;
        tx_busy_r  <= 1'b0;
        tx_load    <= 1'b0;
        pcm_out    <= 1'b0;
        pcm_out_en <= 1'b0;
    end
    else
    begin
        tx_load <= 1'b0;
        if (!tx_active || (variable_s && tx_busy_r && !tx_fs_s))
        begin
            tx_busy_r  <= 1'b0;
            tx_cnt_r   <= 4'h0;
            pcm_out_en <= 1'b0;
        end
        else if (tx_rise && !tx_busy_r && tx_fs_s)
        begin
            pcm_out    <= tx_word_r[7];
            tx_shift_r <= {tx_word_r[6:0], 1'b0};
            tx_cnt_r   <= 4'h1;
            tx_busy_r  <= 1'b1;
            tx_load    <= 1'b1;
            pcm_out_en <= 1'b1;
        end
        else if (tx_rise && tx_busy_r)
        begin
            if (tx_cnt_r == `PCM_WORD_BITS)
            begin
                tx_busy_r  <= 1'b0;
                tx_cnt_r   <= 4'h0;
                pcm_out_en <= 1'b0;
            end
            else
            begin
                pcm_out    <= tx_shift_r[7];
                tx_shift_r <= {tx_shift_r[6:0], 1'b0};
                tx_cnt_r   <= tx_cnt_r + 4'h1;
            end
        end
    end
end

// open drain: pulls low during the slot in fixed mode, else released
assign tx_slot_strobe_or_bit_clock_out = 1'b0;
assign tx_slot_strobe_or_bit_clock_oe  = ~variable_s & tx_busy_r;

// ****************************************************************
// apb slave
// ****************************************************************
wire setup    = psel & ~penable;
wire access   = psel & penable;
wire mapped   = (paddr == `REG_TX_WORD) || (paddr == `REG_RX_WORD) ||
                (paddr == `REG_STATUS);
wire wr_tx    = access & pwrite & (paddr == `REG_TX_WORD);
wire rd_rx    = access & ~pwrite & (paddr == `REG_RX_WORD);

assign pready  = 1'b1; // zero wait states
assign pslverr = access & ~mapped;

reg rx_new_r;
reg tx_taken_r;

// transmit word; writing it also rearms the taken flag
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        tx_word_r <= `TX_WORD_RESET;
    else if (wr_tx)
        tx_word_r <= pwdata[7:0];
end

// sticky flags: a hardware event in the clearing cycle wins
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        rx_new_r   <= 1'b0;
        tx_taken_r <= 1'b0;
    end
    else
    begin
        if (rx_done)
            rx_new_r <= 1'b1;
        else if (rd_rx)
            rx_new_r <= 1'b0;
        if (tx_load)
            tx_taken_r <= 1'b1;
        else if (wr_tx)
            tx_taken_r <= 1'b0;
    end
end

wire [31:0] status_word = {21'h0, freq_s, tx_taken_r, rx_new_r,
                           signaling[1], signaling[0], standby[1],
                           standby[0], powered_s, a_law_s, variable_s};

// read data captured in the setup phase, unmapped reads as zero
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        prdata <= 32'h0;
    else if (setup && !pwrite)
    begin
        case (paddr)
            `REG_TX_WORD: prdata <= {24'h0, tx_word_r};
            `REG_RX_WORD: prdata <= {24'h0, rx_word_r};
            `REG_STATUS:  prdata <= status_word;
            default:      prdata <= 32'h0;
        endcase
    end
end

endmodule

// file: tb/pcm_port_assertions.sv
// concurrent checks on the pcm serial port, bound to its top module.
// assumes a 5 MHz data clock and straps that move only while quiet.
`timescale 1ns/1ps
`include "pcm_port_map.vh"

module pcm_port_assertions
(
    // clock and reset
    input wire        pclk,
    input wire        presetn,
    // apb side
    input wire [11:0] paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // straps and link side
    input wire        mode_strap_vbb,
    input wire        companding_law_strap,
    input wire        power_down_n,
    input wire        tx_slot_strobe_or_bit_clock_out,
    input wire        tx_slot_strobe_or_bit_clock_oe,
    input wire        pcm_out_en
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    reg [8:0] en_len_r;

    // length of the transmit slot in pclk cycles
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            en_len_r <= 9'h000;
        else
            en_len_r <= pcm_out_en ? en_len_r + 9'h001 : 9'h000;
    end

    // straps settled long enough to cross the synchroniser
    sequence s_calm;
        ($stable(mode_strap_vbb) && $stable(companding_law_strap)
            && $stable(power_down_n) && $past(presetn)) [*4];
    endsequence
    sequence s_status_rd;
        psel && !penable && !pwrite && paddr == `REG_STATUS;
    endsequence

    property p_ready;
        psel && penable |-> pready;
    endproperty
    property p_slverr;
        pslverr == (psel && penable && paddr != `REG_TX_WORD && paddr != `REG_RX_WORD
            && paddr != `REG_STATUS);
    endproperty
    property p_unmapped_zero;
        psel && !penable && !pwrite && paddr != `REG_TX_WORD && paddr != `REG_RX_WORD
            && paddr != `REG_STATUS |=> prdata == 32'h0;
    endproperty
    property p_oe_slot;
        s_calm ##0 mode_strap_vbb |-> tx_slot_strobe_or_bit_clock_oe == pcm_out_en;
    endproperty
    property p_od_low;
        tx_slot_strobe_or_bit_clock_oe |-> !tx_slot_strobe_or_bit_clock_out;
    endproperty
    property p_oe_fixed;
        tx_slot_strobe_or_bit_clock_oe |-> mode_strap_vbb;
    endproperty
    property p_pd_quiet;
        !power_down_n [*5] |-> !pcm_out_en && !tx_slot_strobe_or_bit_clock_oe;
    endproperty
    property p_word_len;
        $fell(pcm_out_en) |-> en_len_r >= 9'h03e && en_len_r <= 9'h042;
    endproperty
    property p_mode;
        s_calm ##0 s_status_rd |=> prdata[0] == !$past(mode_strap_vbb);
    endproperty
    property p_law;
        s_calm ##0 s_status_rd |=> prdata[1] == $past(companding_law_strap);
    endproperty
    property p_powered;
        s_calm ##0 s_status_rd |=> prdata[2] == $past(power_down_n);
    endproperty

    a_ready: assert property (p_ready) else $error("pready low in access");
    a_slverr: assert property (p_slverr) else $error("pslverr wrong");
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not 0");
    a_od_low: assert property (p_od_low) else $error("slot strobe drives high");
    a_oe_fixed: assert property (p_oe_fixed) else $error("slot strobe in var mode");
    a_oe_slot: assert property (p_oe_slot) else $error("slot strobe not on slot");
    a_pd_quiet: assert property (p_pd_quiet) else $error("active in power down");
    a_word_len: assert property (p_word_len) else $error("slot not 8 bits");
    a_mode: assert property (p_mode) else $error("mode bit wrong");
    a_law: assert property (p_law) else $error("law bit wrong");
    a_powered: assert property (p_powered) else $error("powered bit wrong");
endmodule

bind pcm_codec_serial_port pcm_port_assertions i_pcm_port_assertions (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_strap_vbb(mode_strap_vbb), .companding_law_strap(companding_law_strap),
    .power_down_n(power_down_n), .pcm_out_en(pcm_out_en),
    .tx_slot_strobe_or_bit_clock_out(tx_slot_strobe_or_bit_clock_out),
    .tx_slot_strobe_or_bit_clock_oe(tx_slot_strobe_or_bit_clock_oe));

// file: tb/highway_model.sv
// highway controller model: data clocks, frame strobes and pcm data.
// assumes the port samples every pin with its own much faster clock.
`timescale 1ns/1ps

module highway_model #(
    parameter HALF = 100,
    parameter GAP  = 62000
)
(
    // mode the port is strapped to
    input  wire var_mode,
    // clocks and strobes
    output wire mclk,
    output wire rx_bclk,
    output wire tx_bclk,
    output reg  rx_stb,
    output reg  tx_stb,
    // pcm data
    output reg  pcm_in,
    input  wire pcm_out
);
    reg     clk_r = 1'b0;
    integer k;

    // one 5 MHz clock, stands still between frames
    assign mclk    = clk_r & ~var_mode;
    assign rx_bclk = clk_r & var_mode;
    assign tx_bclk = clk_r & var_mode;

    initial
    begin
        rx_stb = 1'b0;
        tx_stb = 1'b0;
        pcm_in = 1'b0;
    end

    // one frame; data moves mid-period so both edges see it settled
    task frame(input [7:0] rxb, input rsig, input xsig, output [7:0] txb);
        begin
            #(GAP); // frame rate under 16 kHz
            rx_stb = 1'b1;
            tx_stb = 1'b1;
            for (k = 0; k < 9; k = k + 1)
            begin
                #(HALF);
                if (k > 0)
                    txb[8 - k] = pcm_out; // msb first
                clk_r = 1'b1;
                #(HALF / 2);
                pcm_in = (k < 8) ? rxb[7 - k] : ~pcm_in;
                if (k == (var_mode ? 8 : 1 + rsig))
                    rx_stb = 1'b0; // slot or one/two period sync
                if (k == (var_mode ? 8 : 1 + xsig))
                    tx_stb = 1'b0;
                #(HALF / 2);
                clk_r = 1'b0;
            end
        end
    endtask
endmodule

// file: tb/pcm_codec_serial_port_tb.sv
// self-checking bench: apb tasks reach the registers, the highway
// model moves words; standby count shortened to 200 pclk.
`timescale 1ns/1ps
`include "pcm_port_map.vh"

module pcm_codec_serial_port_tb;
    reg         pclk = 1'b0;
    reg         presetn = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [31:0] pwdata = 32'h0;
    reg         mode_strap_vbb = 1'b1;
    reg         companding_law_strap = 1'b0;
    reg  [1:0]  master_freq_strap = 2'h0;
    reg         power_down_n = 1'b1;
    wire        pready, pslverr, tx_od, oe, pcm_out, pcm_out_en;
    wire        mclk, rx_bclk, tx_bclk, rx_stb, tx_stb, pcm_in;
    wire [31:0] prdata;
    integer     bad_count = 0;
    integer     compares = 0;
    integer     cycles = 0;
    integer     i;
    reg  [31:0] rd;
    reg         err;
    reg  [7:0]  txb, rxw, txw;

    // open drain slot strobe with pull-up, bit clock in variable mode
    wire tx_wire = mode_strap_vbb ? (oe ? tx_od : 1'b1) : tx_bclk;

    pcm_codec_serial_port #(.STANDBY_CYCLES(200)) i_pcm_codec_serial_port (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .mode_strap_vbb(mode_strap_vbb),
        .companding_law_strap(companding_law_strap), .master_freq_strap(master_freq_strap),
        .power_down_n(power_down_n), .rx_master_clock(mclk),
        .rx_bit_clock_or_mode_pin(rx_bclk), .rx_frame_strobe(rx_stb),
        .tx_frame_strobe(tx_stb), .tx_slot_strobe_or_bit_clock_in(tx_wire),
        .tx_slot_strobe_or_bit_clock_out(tx_od), .tx_slot_strobe_or_bit_clock_oe(oe),
        .pcm_in(pcm_in), .pcm_out(pcm_out), .pcm_out_en(pcm_out_en));

    highway_model i_highway_model (
        .var_mode(~mode_strap_vbb), .mclk(mclk), .rx_bclk(rx_bclk), .tx_bclk(tx_bclk),
        .rx_stb(rx_stb), .tx_stb(tx_stb), .pcm_in(pcm_in), .pcm_out(pcm_out));

    // 40 MHz clock and a hang limit
    always #12.5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cycles = cycles + 1;
        if (cycles == 30000)
        begin
            bad_count = bad_count + 1;
            close_out;
        end
    end

    task close_out;
        begin
            $display("compares %0d mismatches %0d", compares, bad_count);
            if (bad_count == 0 && compares > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    task chk(input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp)
            begin
                bad_count = bad_count + 1;
                $display("BAD at %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    // one apb transfer, request held until pready is seen
    task apb(input wr, input [11:0] a, input [31:0] wd);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= wd;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1)
                @(posedge pclk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task rdchk(input [11:0] a, input [31:0] m, input [31:0] e);
        begin
            apb(1'b0, a, 32'h0);
            chk(rd & m, e & m);
        end
    endtask

    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`REG_TX_WORD, 32'hffffffff, 32'h000000ff);
        rdchk(`REG_RX_WORD, 32'hffffffff, 32'h0);
        rdchk(12'h00c, 32'hffffffff, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
        // both law straps and frequency strap codes 0 to 2
        for (i = 0; i < 6; i = i + 1)
        begin
            companding_law_strap <= i[0];
            master_freq_strap <= i[2:1];
            repeat (8) @(posedge pclk);
            rdchk(`REG_STATUS, 32'h607, {21'h0, i[2:1], 6'h0, 1'b1, i[0], 1'b0});
        end
        $display("test straps done");
        // four fixed frames over all sync lengths, then two variable
        for (i = 0; i < 6; i = i + 1)
        begin
            mode_strap_vbb <= (i < 4);
            rxw = 8'hc3 ^ (i[7:0] * 8'h27);
            txw = 8'h3c ^ (i[7:0] * 8'h51);
            repeat (8) @(posedge pclk);
            apb(1'b1, `REG_TX_WORD, {24'h0, txw});
            i_highway_model.frame(rxw, i[0], i[1], txb);
            rdchk(`REG_STATUS, (i < 4) ? 32'h1ff : 32'h19f,
                  {23'h0, 2'h3, i[1], i[0], 2'h0, 2'h3, i > 3});
            rdchk(`REG_RX_WORD, 32'hff, {24'h0, rxw});
            chk({24'h0, txb}, {24'h0, txw});
        end
        $display("test frames done");
        repeat (250) @(posedge pclk);
        rdchk(`REG_STATUS, 32'h18, 32'h18);
        $display("test standby done");
        power_down_n <= 1'b0;
        repeat (8) @(posedge pclk);
        i_highway_model.frame(8'h55, 1'b0, 1'b0, txb);
        rdchk(`REG_STATUS, 32'h84, 32'h0);
        power_down_n <= 1'b1;
        $display("test power down done");
        close_out;
    end
endmodule
